// ===== hw/dbw_unit.sv
/*
  Debug breakpoint and watchpoint unit: context capture on debugger entry,
  cause recording, remote read operands, thread stop vector, scratch words,
  four instruction breakpoints, four data and four resource watchpoints.
  Assumes the core feeds one trace per cycle for fetch, memory and resource
  use, pulses debug exit on return, and that the register port is the only
  software path (the tile scratch view shares the same storage).
*/
// Summary of operation
// R1 - on debugger entry, capture the interrupted thread's PC into saved PC
// R2 - on debugger entry, capture the interrupted thread's stack pointer
// R3 - remote read thread operand: low eight bits, upper bits read zero
// R4 - remote read register operand: five bits, upper bits read zero
// R5 - cause: 1 host, 2 debug call, 3 ibreak, 4 data, 5 resource; resets 0
// R6 - unit number is lowest firing unit; zero for host and debug call
// R7 - record causing thread; zero when host initiated
// R8 - event data gets access address on data watch, resource id on resource
// R9 - set stop vector bits keep threads stopped outside debug mode
// R10 - on return from debug, stopped threads do not resume
// R11 - eight 32-bit read-write scratch words shared with tile space
// R12 - four instruction breakpoints, each with a 32-bit address
// R13 - ibreak control bit 1: clear breaks on equal, set on differ
// R14 - every control register has an eight-bit thread mask, reset zero
// R15 - control bit 0 enables the unit; resets disabled
// R16 - four data watchpoints, each with two 32-bit addresses
// R17 - data control bit 1: clear needs A and B, set needs A or B
// R18 - data control bit 2 set also triggers on loads
// R19 - four resource watchpoints with 32-bit mask and value
// R20 - resource control bit 1: clear breaks on A, set breaks on B
// R21 - enabled unit trigger outside debug mode raises debug interrupt and updates cause, unit and thread fields
`timescale 1ns/1ps
`default_nettype none
module dbw_unit
  import dbw_pkg::*;
#(
  parameter int NUNIT = 4,
  parameter int NSCR  = 8
)(
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic [9:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WE,
  input  wire logic        RE,
  output logic      [31:0] RDATA,
  input  wire logic        HOST_REQ,
  input  wire logic        DEBUG_CALL_INSTRUCTION_REQ,
  input  wire logic [2:0]  DEBUG_CALL_INSTRUCTION_THREAD,
  input  wire logic        DEBUG_EXIT,
  input  wire logic [31:0] CTX_PC,
  input  wire logic [31:0] CTX_SP,
  input  wire dbw_trace_t  PC_TRACE,
  input  wire dbw_trace_t  MEM_TRACE,
  input  wire dbw_trace_t  RES_TRACE,
  output logic             DEBUG_IRQ,
  output logic             DEBUG_MODE,
  output logic      [7:0]  THREAD_STOP,
  output logic      [7:0]  REMOTE_THREAD,
  output logic      [4:0]  REMOTE_REG
);

  logic [31:0]        saved_pc;
  logic [31:0]        saved_sp;
  logic [2:0]         cause;
  logic [1:0]         unit_num;
  logic [7:0]         cause_thread;
  logic [31:0]        event_data;
  logic [7:0]         stop_vec;
  logic [31:0]        scratch [NSCR];
  logic [31:0]        ib_addr [NUNIT];
  dbw_ctl_t           ib_ctl  [NUNIT];
  logic [31:0]        dw_a    [NUNIT];
  logic [31:0]        dw_b    [NUNIT];
  dbw_ctl_t           dw_ctl  [NUNIT];
  logic [31:0]        rw_mask [NUNIT];
  logic [31:0]        rw_val  [NUNIT];
  dbw_ctl_t           rw_ctl  [NUNIT];
  logic [NUNIT-1:0]   ib_hit;
  logic [NUNIT-1:0]   dw_hit;
  logic [NUNIT-1:0]   rw_hit;
  logic [7:0]         widx;
  logic               take;
  logic [2:0]         next_cause;
  logic [1:0]         next_unit;
  logic [7:0]         next_thread;
  logic [31:0]        next_data;
  logic               next_mode;
  logic [31:0]        next_rdata;

  assign widx = ADDR[9:2];

  // per-unit trigger conditions
  always_comb
  begin
    for (int i = 0; i < NUNIT; i++)
    begin
      // instruction breakpoint: equal or not-equal compare, thread masked
      ib_hit[i] = ib_ctl[i].en && PC_TRACE.valid && ib_ctl[i].mask[PC_TRACE.thread] // R12 R14 R15
                  && ((PC_TRACE.value == ib_addr[i]) != ib_ctl[i].mode);           // R13
      // data watch: A is address at or above first, B at or below second
      dw_hit[i] = dw_ctl[i].en && MEM_TRACE.valid && dw_ctl[i].mask[MEM_TRACE.thread] // R14 R15 R16
                  && (!MEM_TRACE.is_load || dw_ctl[i].load)                           // R18
                  && (dw_ctl[i].mode ? ((MEM_TRACE.value >= dw_a[i]) || (MEM_TRACE.value <= dw_b[i]))
                                     : ((MEM_TRACE.value >= dw_a[i]) && (MEM_TRACE.value <= dw_b[i]))); // R17
      // resource watch: A is masked id equals value, B is masked id differs
      rw_hit[i] = rw_ctl[i].en && RES_TRACE.valid && rw_ctl[i].mask[RES_TRACE.thread] // R14 R15 R19
                  && (((RES_TRACE.value & rw_mask[i]) == rw_val[i]) == !rw_ctl[i].mode); // R20
    end
  end

  // entry decision and cause fields; host first, then call, ibreak, data, resource
  always_comb
  begin
    next_cause  = DBW_CAUSE_NONE;
    next_unit   = 2'h0;
    next_thread = RST_BYTE;
    next_data   = event_data;
    if (HOST_REQ)
    begin
      next_cause = DBW_CAUSE_HOST; // R5 R6 R7
    end
    else if (DEBUG_CALL_INSTRUCTION_REQ)
    begin
      next_cause  = DBW_CAUSE_DEBUG_CALL_INSTRUCTION; // R5 R6
      next_thread = {5'h00, DEBUG_CALL_INSTRUCTION_THREAD}; // R7
    end
    else if (|ib_hit)
    begin
      next_cause  = DBW_CAUSE_IBRK; // R5
      next_thread = {5'h00, PC_TRACE.thread}; // R7
      for (int i = NUNIT - 1; i >= 0; i--)
        if (ib_hit[i])
          next_unit = 2'(i); // R6
    end
    else if (|dw_hit)
    begin
      next_cause  = DBW_CAUSE_DWTCH; // R5
      next_thread = {5'h00, MEM_TRACE.thread}; // R7
      next_data   = MEM_TRACE.value; // R8
      for (int i = NUNIT - 1; i >= 0; i--)
        if (dw_hit[i])
          next_unit = 2'(i); // R6
    end
    else if (|rw_hit)
    begin
      next_cause  = DBW_CAUSE_RWTCH; // R5
      next_thread = {5'h00, RES_TRACE.thread}; // R7
      next_data   = RES_TRACE.value; // R8
      for (int i = NUNIT - 1; i >= 0; i--)
        if (rw_hit[i])
          next_unit = 2'(i); // R6
    end
  end

  assign take      = !DEBUG_MODE && (next_cause != DBW_CAUSE_NONE); // R21
  assign next_mode = take || (DEBUG_MODE && !DEBUG_EXIT);

  // debug mode, interrupt pulse and thread stop outputs
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      DEBUG_MODE  <= 1'b0;
      DEBUG_IRQ   <= 1'b0;
      THREAD_STOP <= RST_BYTE;
    end
    else
    begin
      DEBUG_MODE  <= next_mode;
      DEBUG_IRQ   <= take; // R21
      // all threads held in debug mode; outside it the stop vector holds them
      THREAD_STOP <= next_mode ? 8'hFF : stop_vec; // R9 R10
    end
  end

  // saved context; entry capture wins over a software write
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      saved_pc <= RST_WORD;
      saved_sp <= RST_WORD;
    end
    else if (take)
    begin
      saved_pc <= CTX_PC; // R1
      saved_sp <= CTX_SP; // R2
    end
    else if (WE)
    begin
      if (widx == IDX_SAVED_PC)
        saved_pc <= WDATA;
      if (widx == IDX_SAVED_SP)
        saved_sp <= WDATA;
    end
  end

  // cause record; entry wins over a software write
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      cause        <= DBW_CAUSE_NONE; // R5
      unit_num     <= 2'h0;
      cause_thread <= RST_BYTE;
      event_data   <= RST_WORD;
    end
    else if (take)
    begin
      cause        <= next_cause; // R21
      unit_num     <= next_unit;
      cause_thread <= next_thread;
      event_data   <= next_data;
    end
    else if (WE)
    begin
      if (widx == IDX_CAUSE)
      begin
        cause        <= WDATA[2:0];
        unit_num     <= WDATA[CAUSE_UNIT_LSB +: 2];
        cause_thread <= WDATA[CAUSE_THR_LSB +: 8];
      end
      if (widx == IDX_EVENT_DATA)
        event_data <= WDATA;
    end
  end

  // remote read operands and stop vector
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      REMOTE_THREAD <= RST_BYTE;
      REMOTE_REG    <= 5'h00;
      stop_vec      <= RST_BYTE;
    end
    else if (WE)
    begin
      if (widx == IDX_RD_THREAD)
        REMOTE_THREAD <= WDATA[7:0]; // R3
      if (widx == IDX_RD_REG)
        REMOTE_REG <= WDATA[RD_REG_W-1:0]; // R4
      if (widx == IDX_STOP_VEC)
        stop_vec <= WDATA[7:0]; // R9
    end
  end

  // scratch words
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < NSCR; i++)
        scratch[i] <= RST_WORD;
    end
    else if (WE)
    begin
      for (int i = 0; i < NSCR; i++)
        if (widx == IDX_SCRATCH + 8'(i))
          scratch[i] <= WDATA; // R11
    end
  end

  // breakpoint and watchpoint address, mask and value words
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < NUNIT; i++)
      begin
        ib_addr[i] <= RST_WORD;
        dw_a[i]    <= RST_WORD;
        dw_b[i]    <= RST_WORD;
        rw_mask[i] <= RST_WORD;
        rw_val[i]  <= RST_WORD;
      end
    end
    else if (WE)
    begin
      for (int i = 0; i < NUNIT; i++)
      begin
        if (widx == IDX_IB_ADDR + 8'(i))
          ib_addr[i] <= WDATA; // R12
        if (widx == IDX_DW_ADDR_A + 8'(i))
          dw_a[i] <= WDATA; // R16
        if (widx == IDX_DW_ADDR_B + 8'(i))
          dw_b[i] <= WDATA; // R16
        if (widx == IDX_RW_MASK + 8'(i))
          rw_mask[i] <= WDATA; // R19
        if (widx == IDX_RW_VALUE + 8'(i))
          rw_val[i] <= WDATA; // R19
      end
    end
  end

  // control registers: all disabled with zero thread masks after reset, so no thread is selected
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < NUNIT; i++)
      begin
        ib_ctl[i] <= '0; // R14 R15
        dw_ctl[i] <= '0;
        rw_ctl[i] <= '0;
      end
    end
    else if (WE)
    begin
      for (int i = 0; i < NUNIT; i++)
      begin
        if (widx == IDX_IB_CTL + 8'(i))
          ib_ctl[i] <= '{mask: WDATA[CTL_MASK_LSB +: 8], load: 1'b0,
                         mode: WDATA[CTL_MODE_BIT], en: WDATA[CTL_EN_BIT]}; // R13 R14 R15
        if (widx == IDX_DW_CTL + 8'(i))
          dw_ctl[i] <= '{mask: WDATA[CTL_MASK_LSB +: 8], load: WDATA[CTL_LOAD_BIT],
                         mode: WDATA[CTL_MODE_BIT], en: WDATA[CTL_EN_BIT]}; // R17 R18
        if (widx == IDX_RW_CTL + 8'(i))
          rw_ctl[i] <= '{mask: WDATA[CTL_MASK_LSB +: 8], load: 1'b0,
                         mode: WDATA[CTL_MODE_BIT], en: WDATA[CTL_EN_BIT]}; // R20
      end
    end
  end

  // read mux; reserved bits and unmapped words read zero
  always_comb
  begin
    next_rdata = RST_WORD;
    case (widx)
      IDX_SAVED_PC:   next_rdata = saved_pc;
      IDX_SAVED_SP:   next_rdata = saved_sp;
      IDX_RD_THREAD:  next_rdata = {24'h000000, REMOTE_THREAD}; // R3
      IDX_RD_REG:     next_rdata = {27'h0000000, REMOTE_REG}; // R4
      IDX_CAUSE:      next_rdata = {14'h0000, unit_num, cause_thread, 5'h00, cause};
      IDX_EVENT_DATA: next_rdata = event_data;
      IDX_STOP_VEC:   next_rdata = {24'h000000, stop_vec};
      default:
      begin
        for (int i = 0; i < NSCR; i++)
          if (widx == IDX_SCRATCH + 8'(i))
            next_rdata = scratch[i]; // R11
        for (int i = 0; i < NUNIT; i++)
        begin
          if (widx == IDX_IB_ADDR + 8'(i))
            next_rdata = ib_addr[i];
          if (widx == IDX_IB_CTL + 8'(i))
            next_rdata = {8'h00, ib_ctl[i].mask, 14'h0000, ib_ctl[i].mode, ib_ctl[i].en};
          if (widx == IDX_DW_ADDR_A + 8'(i))
            next_rdata = dw_a[i];
          if (widx == IDX_DW_ADDR_B + 8'(i))
            next_rdata = dw_b[i];
          if (widx == IDX_DW_CTL + 8'(i))
            next_rdata = {8'h00, dw_ctl[i].mask, 13'h0000, dw_ctl[i].load, dw_ctl[i].mode, dw_ctl[i].en};
          if (widx == IDX_RW_MASK + 8'(i))
            next_rdata = rw_mask[i];
          if (widx == IDX_RW_VALUE + 8'(i))
            next_rdata = rw_val[i];
          if (widx == IDX_RW_CTL + 8'(i))
            next_rdata = {8'h00, rw_ctl[i].mask, 14'h0000, rw_ctl[i].mode, rw_ctl[i].en};
        end
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
      RDATA <= RST_WORD;
    else if (RE)
      RDATA <= next_rdata;
    else
      RDATA <= RST_WORD;
  end

endmodule
`default_nettype wire

// ===== hw/dbw_pkg.sv
/*
  Constants, field layouts and carrier types for the debug breakpoint and
  watchpoint unit. Assumes a register port that addresses 32-bit words at
  four times their register index.
*/
package dbw_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SAVED_PC     = 8'h11;
  localparam logic [7:0] IDX_SAVED_SP     = 8'h12;
  localparam logic [7:0] IDX_RD_THREAD    = 8'h13;
  localparam logic [7:0] IDX_RD_REG       = 8'h14;
  localparam logic [7:0] IDX_CAUSE        = 8'h15;
  localparam logic [7:0] IDX_EVENT_DATA   = 8'h16;
  localparam logic [7:0] IDX_STOP_VEC     = 8'h18;
  localparam logic [7:0] IDX_SCRATCH      = 8'h20;
  localparam logic [7:0] IDX_IB_ADDR      = 8'h30;
  localparam logic [7:0] IDX_IB_CTL       = 8'h40;
  localparam logic [7:0] IDX_DW_ADDR_A    = 8'h50;
  localparam logic [7:0] IDX_DW_ADDR_B    = 8'h60;
  localparam logic [7:0] IDX_DW_CTL       = 8'h70;
  localparam logic [7:0] IDX_RW_MASK      = 8'h80;
  localparam logic [7:0] IDX_RW_VALUE     = 8'h90;
  localparam logic [7:0] IDX_RW_CTL       = 8'h9C;
  // field positions
  localparam int CTL_EN_BIT     = 0;
  localparam int CTL_MODE_BIT   = 1;
  localparam int CTL_LOAD_BIT   = 2;
  localparam int CTL_MASK_LSB   = 16;
  localparam int CAUSE_UNIT_LSB = 16;
  localparam int CAUSE_THR_LSB  = 8;
  localparam int RD_REG_W       = 5;
  // debug cause codes
  typedef enum logic [2:0] {
    DBW_CAUSE_NONE  = 3'h0,
    DBW_CAUSE_HOST  = 3'h1,
    DBW_CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2,
    DBW_CAUSE_IBRK  = 3'h3,
    DBW_CAUSE_DWTCH = 3'h4,
    DBW_CAUSE_RWTCH = 3'h5
  } dbw_cause_t;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  // one observed core event: instruction fetch, memory access or resource use
  typedef struct packed {
    logic        valid;
    logic        is_load;
    logic [2:0]  thread;
    logic [31:0] value;
  } dbw_trace_t;
  // unit control fields
  typedef struct packed {
    logic [7:0] mask;
    logic       load;
    logic       mode;
    logic       en;
  } dbw_ctl_t;
endpackage

// ===== verification/dbw_unit_checker.sv
/* port checker for dbw_unit: entry, exit, stop vector and read port
   assumes one core clock and a synchronous active-low reset */
`timescale 1ns/1ps
`default_nettype none
module dbw_unit_checker
  import dbw_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RSTN,
  input wire logic [9:0]  ADDR,
  input wire logic        RE,
  input wire logic [31:0] RDATA,
  input wire logic        HOST_REQ,
  input wire logic        DEBUG_CALL_INSTRUCTION_REQ,
  input wire logic        DEBUG_EXIT,
  input wire logic        DEBUG_IRQ,
  input wire logic        DEBUG_MODE,
  input wire logic [7:0]  THREAD_STOP
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  // debug entry and exit sequencing
  chk_host_entry: assert property (!DEBUG_MODE && HOST_REQ |=> DEBUG_IRQ && DEBUG_MODE)
    else $error("host request did not enter debug");
  chk_call_entry: assert property (!DEBUG_MODE && DEBUG_CALL_INSTRUCTION_REQ |=> DEBUG_IRQ)
    else $error("debug call did not enter debug");
  chk_irq_pulse: assert property (DEBUG_IRQ |=> !DEBUG_IRQ)
    else $error("irq longer than one cycle");
  chk_irq_mode: assert property (DEBUG_IRQ |-> DEBUG_MODE && !$past(DEBUG_MODE))
    else $error("irq without fresh entry");
  chk_mode_rise: assert property ($rose(DEBUG_MODE) |-> DEBUG_IRQ)
    else $error("mode rose without irq");
  chk_mode_hold: assert property (DEBUG_MODE && !DEBUG_EXIT |=> DEBUG_MODE [*1])
    else $error("mode left without exit");
  chk_exit_mode: assert property (DEBUG_MODE && DEBUG_EXIT |=> !DEBUG_MODE && !DEBUG_IRQ)
    else $error("exit did not leave debug");
  chk_stop_all: assert property (DEBUG_MODE |-> THREAD_STOP == 8'hFF)
    else $error("threads free inside debug");
  // read port
  chk_rdata_idle: assert property (!RE |=> RDATA == 32'h0)
    else $error("read data without strobe");
  chk_thread_ro: assert property (RE && ADDR[9:2] == IDX_RD_THREAD |=> RDATA[31:8] == 24'h0)
    else $error("thread operand upper bits set");
  chk_reg_ro: assert property (RE && ADDR[9:2] == IDX_RD_REG |=> RDATA[31:5] == 27'h0)
    else $error("register operand upper bits set");
  cov_host: cover property (HOST_REQ && !DEBUG_MODE ##1 DEBUG_IRQ);
  cov_exit: cover property (DEBUG_MODE && DEBUG_EXIT);
  cov_read: cover property (RE ##1 RDATA != 32'h0);
endmodule
bind dbw_unit dbw_unit_checker u_chk (.CORE_CLK, .RSTN, .ADDR, .RE, .RDATA, .HOST_REQ, .DEBUG_CALL_INSTRUCTION_REQ,
  .DEBUG_EXIT, .DEBUG_IRQ, .DEBUG_MODE, .THREAD_STOP);
`default_nettype wire

// ===== verification/dbw_core_model.sv
/* core and debugger side model: one-cycle requests, traces and context
   assumes the bench calls ev between clock edges */
`timescale 1ns/1ps
`default_nettype none
module dbw_core_model
  import dbw_pkg::*;
(
  input  wire logic        CORE_CLK,
  output var logic         HOST_REQ,
  output var logic         DEBUG_CALL_INSTRUCTION_REQ,
  output var logic  [2:0]  DEBUG_CALL_INSTRUCTION_THREAD,
  output var logic         DEBUG_EXIT,
  output var logic  [31:0] CTX_PC,
  output var logic  [31:0] CTX_SP,
  output var dbw_trace_t   PC_TRACE,
  output var dbw_trace_t   MEM_TRACE,
  output var dbw_trace_t   RES_TRACE
);
  // idle state; idle trace values differ from any live one
  initial
  begin
    {HOST_REQ, DEBUG_CALL_INSTRUCTION_REQ, DEBUG_EXIT, DEBUG_CALL_INSTRUCTION_THREAD} = 6'h00;
    {CTX_PC, CTX_SP} = 64'h0;
    {PC_TRACE, MEM_TRACE, RES_TRACE} = '0;
  end
  // k: 0 host, 1 call, 2 fetch, 3 memory, 4 resource, 5 exit
  task automatic ev(input int k, input logic [2:0] t, input logic [31:0] v, input logic ld);
    dbw_trace_t e;
    e = '{valid: 1'b1, is_load: ld, thread: t, value: v};
    @(posedge CORE_CLK);
    CTX_PC <= 32'h4000_0000 | v;
    CTX_SP <= ~v;
    HOST_REQ <= (k == 0);
    DEBUG_CALL_INSTRUCTION_REQ <= (k == 1);
    DEBUG_CALL_INSTRUCTION_THREAD <= t;
    DEBUG_EXIT <= (k == 5);
    if (k == 2) PC_TRACE <= e;
    if (k == 3) MEM_TRACE <= e;
    if (k == 4) RES_TRACE <= e;
    @(posedge CORE_CLK);
    {HOST_REQ, DEBUG_CALL_INSTRUCTION_REQ, DEBUG_EXIT} <= 3'h0;
    DEBUG_CALL_INSTRUCTION_THREAD <= ~t;
    CTX_PC <= ~v;
    e = '{valid: 1'b0, is_load: ~ld, thread: ~t, value: ~v};
    PC_TRACE <= e;
    MEM_TRACE <= e;
    RES_TRACE <= e;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
/* self-checking bench for dbw_unit: register tasks and debug entries
   assumes dbw_core_model on the core side and the bound checker */
`timescale 1ns/1ps
`default_nettype none
module tb
  import dbw_pkg::*;
();
  logic        CORE_CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic [9:0]  ADDR = 10'h000;
  logic [31:0] WDATA = 32'h0;
  logic        WE = 1'b0;
  logic        RE = 1'b0;
  logic [31:0] RDATA, CTX_PC, CTX_SP;
  logic        HOST_REQ, DEBUG_CALL_INSTRUCTION_REQ, DEBUG_EXIT, DEBUG_IRQ, DEBUG_MODE;
  logic [2:0]  DEBUG_CALL_INSTRUCTION_THREAD;
  dbw_trace_t  PC_TRACE, MEM_TRACE, RES_TRACE;
  logic [7:0]  THREAD_STOP, REMOTE_THREAD;
  logic [4:0]  REMOTE_REG;
  int          fails = 0;
  int          n_checks = 0;
  int          i;
  // 10 MHz core clock
  always #50 CORE_CLK = ~CORE_CLK;
  dbw_unit u_dut (.CORE_CLK, .RSTN, .ADDR, .WDATA, .WE, .RE, .RDATA, .HOST_REQ, .DEBUG_CALL_INSTRUCTION_REQ, .DEBUG_CALL_INSTRUCTION_THREAD,
    .DEBUG_EXIT, .CTX_PC, .CTX_SP, .PC_TRACE, .MEM_TRACE, .RES_TRACE, .DEBUG_IRQ, .DEBUG_MODE,
    .THREAD_STOP, .REMOTE_THREAD, .REMOTE_REG);
  dbw_core_model u_core (.CORE_CLK, .HOST_REQ, .DEBUG_CALL_INSTRUCTION_REQ, .DEBUG_CALL_INSTRUCTION_THREAD, .DEBUG_EXIT, .CTX_PC, .CTX_SP,
    .PC_TRACE, .MEM_TRACE, .RES_TRACE);
  // comparison and register port tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge CORE_CLK);
    ADDR <= {idx, 2'b00};
    WDATA <= d;
    WE <= 1'b1;
    @(posedge CORE_CLK);
    WE <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    @(posedge CORE_CLK);
    ADDR <= {idx, 2'b00};
    RE <= 1'b1;
    @(posedge CORE_CLK);
    RE <= 1'b0;
    #1 cmp(RDATA, exp);
  endtask
  // one core event, then cause word, context and data checks and exit
  task automatic hit(input int k, input logic [2:0] t, input logic [31:0] v, input logic ld,
                     input dbw_cause_t c, input logic [1:0] u);
    u_core.ev(k, t, v, ld);
    #1 cmp({31'h0, DEBUG_IRQ}, {31'h0, c != DBW_CAUSE_NONE});
    cmp({24'h0, THREAD_STOP}, (c != DBW_CAUSE_NONE) ? 32'h0000_00FF : 32'h0000_005A);
    if (c != DBW_CAUSE_NONE)
    begin
      rc(IDX_CAUSE, {14'h0, u, 5'h0, t, 5'h0, c});
      rc(IDX_SAVED_PC, 32'h4000_0000 | v);
      rc(IDX_SAVED_SP, ~v);
      if (c > DBW_CAUSE_IBRK) rc(IDX_EVENT_DATA, v);
      u_core.ev(5, 3'h0, 32'h0, 1'b0);
      #1 cmp({24'h0, THREAD_STOP}, 32'h0000_005A);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    fails++;
    summarize();
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    rc(IDX_CAUSE, RST_WORD);
    rc(IDX_STOP_VEC, RST_WORD);
    for (i = 0; i < 4; i++)
    begin
      rc(IDX_IB_CTL + i[7:0], RST_WORD);
      rc(IDX_DW_CTL + i[7:0], RST_WORD);
      rc(IDX_RW_CTL + i[7:0], RST_WORD);
    end
    wr(IDX_RD_THREAD, 32'hFFFF_FFFF);
    wr(IDX_RD_REG, 32'hFFFF_FFFF);
    rc(IDX_RD_THREAD, 32'h0000_00FF);
    rc(IDX_RD_REG, 32'h0000_001F);
    cmp({24'h0, REMOTE_THREAD}, 32'h0000_00FF);
    cmp({27'h0, REMOTE_REG}, 32'h0000_001F);
    wr(8'h17, 32'hFFFF_FFFF);
    rc(8'h17, RST_WORD);
    for (i = 0; i < 8; i++) wr(IDX_SCRATCH + i[7:0], 32'hA5C3_0000 + i);
    for (i = 0; i < 8; i++) rc(IDX_SCRATCH + i[7:0], 32'hA5C3_0000 + i);
    wr(IDX_STOP_VEC, 32'hFFFF_FF5A);
    rc(IDX_STOP_VEC, 32'h0000_005A);
    cmp({24'h0, THREAD_STOP}, 32'h0000_005A);
    hit(0, 3'h0, 32'h0000_0088, 1'b0, DBW_CAUSE_HOST, 2'h0);
    hit(1, 3'h5, 32'h0000_0123, 1'b0, DBW_CAUSE_DEBUG_CALL_INSTRUCTION, 2'h0);
    wr(IDX_IB_ADDR + 8'h2, 32'h0000_1234);
    wr(IDX_IB_ADDR + 8'h3, 32'h0000_1234);
    wr(IDX_IB_CTL + 8'h2, 32'h0010_0001);
    wr(IDX_IB_CTL + 8'h3, 32'h0010_0001);
    hit(2, 3'h4, 32'h0000_1234, 1'b0, DBW_CAUSE_IBRK, 2'h2);
    hit(1, 3'h6, 32'h0000_0456, 1'b0, DBW_CAUSE_DEBUG_CALL_INSTRUCTION, 2'h0);
    hit(0, 3'h0, 32'h0000_0789, 1'b0, DBW_CAUSE_HOST, 2'h0);
    hit(2, 3'h3, 32'h0000_1234, 1'b0, DBW_CAUSE_NONE, 2'h0);
    hit(2, 3'h4, 32'h0000_1238, 1'b0, DBW_CAUSE_NONE, 2'h0);
    wr(IDX_IB_CTL + 8'h2, 32'h0010_0003);
    hit(2, 3'h4, 32'h0000_1238, 1'b0, DBW_CAUSE_IBRK, 2'h2);
    wr(IDX_IB_CTL + 8'h2, RST_WORD);
    wr(IDX_IB_CTL + 8'h3, RST_WORD);
    hit(2, 3'h4, 32'h0000_1234, 1'b0, DBW_CAUSE_NONE, 2'h0);
    wr(IDX_DW_ADDR_A + 8'h1, 32'h0000_0100);
    wr(IDX_DW_ADDR_B + 8'h1, 32'h0000_01FF);
    wr(IDX_DW_CTL + 8'h1, 32'h0002_0001);
    hit(3, 3'h1, 32'h0000_0180, 1'b0, DBW_CAUSE_DWTCH, 2'h1);
    hit(3, 3'h1, 32'h0000_0180, 1'b1, DBW_CAUSE_NONE, 2'h0);
    hit(3, 3'h1, 32'h0000_0200, 1'b0, DBW_CAUSE_NONE, 2'h0);
    wr(IDX_DW_CTL + 8'h1, 32'h0002_0007);
    hit(3, 3'h1, 32'h0000_0180, 1'b1, DBW_CAUSE_DWTCH, 2'h1);
    hit(3, 3'h1, 32'h0000_0200, 1'b0, DBW_CAUSE_DWTCH, 2'h1);
    wr(IDX_DW_CTL + 8'h1, RST_WORD);
    wr(IDX_RW_MASK, 32'hFFFF_0000);
    wr(IDX_RW_VALUE, 32'h1234_0000);
    wr(IDX_RW_CTL, 32'h0001_0001);
    hit(4, 3'h0, 32'h1234_5678, 1'b0, DBW_CAUSE_RWTCH, 2'h0);
    hit(4, 3'h0, 32'h4321_0000, 1'b0, DBW_CAUSE_NONE, 2'h0);
    wr(IDX_RW_CTL, 32'h0001_0003);
    hit(4, 3'h0, 32'h4321_0000, 1'b0, DBW_CAUSE_RWTCH, 2'h0);
    summarize();
  end
endmodule
`default_nettype wire
